/* hdl/mssc_top.sv */
// Busy indicator, mode selection, address filter and fault reporting logic.
`timescale 1ns/10ps
`include "mssc_regs.svh"
module mssc_top (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic srst_i,
  // Mode pins and busy sources.
  input wire logic mode_select_low_i,
  input wire logic mode_select_high_i,
  input wire mssc_pkg::mssc_busy_t busy_src_i,
  // Faults and configuration.
  input wire mssc_pkg::mssc_fault_t fault_i,
  input wire logic [7:0] cfg_reg04_i,
  // Received packet address check.
  input wire mssc_pkg::mssc_addr_t addr_i,
  // Fault log byte stream.
  input wire logic log_ready_i,
  output logic log_valid_o,
  output logic [7:0] log_data_o,
  // Status and mode outputs.
  output logic busy_n_o,
  output logic fault_led_o,
  output mssc_pkg::mssc_mode_t mode_o,
  output logic serial_en_o,
  output logic radio_rx_en_o,
  output logic radio_tx_en_o,
  output logic cfg_access_o,
  output logic rx_accept_o
);
  import mssc_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers.
  // ----------------------------------------------------------------
  function automatic mssc_mode_t mssc_decode(input logic hi, input logic lo);
    mssc_decode = mssc_mode_t'({hi, lo});
  endfunction : mssc_decode

  function automatic logic [7:0] mssc_code(input mssc_fault_t f);
    if (f.over_volt && f.over_temp) begin
      mssc_code = `MSSC_CODE_OVOT;
    end else if (f.over_volt) begin
      mssc_code = `MSSC_CODE_OV;
    end else if (f.over_temp) begin
      mssc_code = `MSSC_CODE_OT;
    end else begin
      mssc_code = `MSSC_CODE_UV;
    end
  endfunction : mssc_code

  function automatic logic mssc_all_ones(input logic [15:0] a);
    mssc_all_ones = (a == `MSSC_ADDR_ALL);
  endfunction : mssc_all_ones

  // ----------------------------------------------------------------
  // Mode control and busy indicator.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MSSC_ST_INIT, MSSC_ST_RUN, MSSC_ST_WAIT} mssc_st_t;
  mssc_st_t st_reg, st_next;
  mssc_mode_t mode_reg, mode_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] hold_reg, hold_next;
  logic busy_reg, busy_next;
  logic src_busy;
  mssc_mode_t pin_mode;

  assign pin_mode = mssc_decode(mode_select_high_i, mode_select_low_i);
  assign src_busy = busy_src_i.tx_buf_busy | busy_src_i.rx_out_busy
                  | busy_src_i.user_data_busy;

  always_comb begin
    st_next = st_reg;
    mode_next = mode_reg;
    cnt_next = cnt_reg;
    hold_next = hold_reg;
    case (st_reg)
      MSSC_ST_INIT: begin
        if (cnt_reg != 32'd0) begin
          cnt_next = cnt_reg - 32'd1;
        end else if (src_busy) begin
          cnt_next = 32'd0;
        end else begin
          mode_next = pin_mode;
          st_next = MSSC_ST_RUN;
          hold_next = `MSSC_SETTLE_CYC;
        end
      end
      MSSC_ST_RUN: begin
        if (hold_reg != 32'd0 && !src_busy) begin
          hold_next = hold_reg - 32'd1;
        end
        if (src_busy) begin
          hold_next = `MSSC_SETTLE_CYC;
        end else if (pin_mode != mode_reg) begin
          if (hold_reg == 32'd0) begin
            cnt_next = 32'd0;
          end else begin
            cnt_next = hold_reg;
          end
          st_next = MSSC_ST_WAIT;
        end
      end
      MSSC_ST_WAIT: begin
        if (src_busy) begin
          st_next = MSSC_ST_RUN;
          hold_next = `MSSC_SETTLE_CYC;
        end else if (cnt_reg != 32'd0) begin
          cnt_next = cnt_reg - 32'd1;
        end else if (mode_reg == MSSC_MODE_SLEEP && pin_mode != MSSC_MODE_SLEEP) begin
          st_next = MSSC_ST_INIT;
          cnt_next = `MSSC_RELOAD_CYC;
        end else begin
          mode_next = pin_mode;
          st_next = MSSC_ST_RUN;
          hold_next = 32'd0;
        end
      end
      default: begin
        st_next = MSSC_ST_INIT;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_reg <= MSSC_ST_INIT;
      mode_reg <= MSSC_MODE_XFER;
      cnt_reg <= `MSSC_SELFTEST_CYC;
      hold_reg <= 32'd0;
    end else begin
      st_reg <= st_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
    end
  end

  // ----------------------------------------------------------------
  // Busy indicator.
  // ----------------------------------------------------------------
  always_comb begin
    busy_next = !(st_reg == MSSC_ST_INIT || src_busy);
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs.
  // ----------------------------------------------------------------
  logic run_active;
  assign run_active = (st_reg != MSSC_ST_INIT);
  assign busy_n_o = busy_reg;
  assign mode_o = mode_reg;
  assign serial_en_o = run_active && (mode_reg != MSSC_MODE_SLEEP);
  assign radio_rx_en_o = run_active
                       && (mode_reg == MSSC_MODE_XFER || mode_reg == MSSC_MODE_WOR);
  assign radio_tx_en_o = radio_rx_en_o && (fault_i == 3'b000);
  assign cfg_access_o = run_active && (mode_reg == MSSC_MODE_CFG);

  // ----------------------------------------------------------------
  // Address filter.
  // ----------------------------------------------------------------
  logic acc_reg, acc_next;
  always_comb begin
    acc_next = 1'b0;
    if (addr_i.own_chan == addr_i.pkt_chan) begin
      if (mssc_all_ones(addr_i.dest_addr)) begin
        acc_next = 1'b1;
      end else if (mssc_all_ones(addr_i.own_addr)) begin
        acc_next = 1'b1;
      end else if (addr_i.dest_addr == addr_i.own_addr) begin
        acc_next = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      acc_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
    end
  end
  assign rx_accept_o = acc_reg;

  // ----------------------------------------------------------------
  // Fault indicator.
  // ----------------------------------------------------------------
  logic [31:0] blink_reg, blink_next;
  logic led_reg, led_next;
  logic [31:0] half;
  logic any_fault;

  assign any_fault = fault_i != 3'b000;

  always_comb begin
    half = `MSSC_UV_MS * `MSSC_MS_CYC;
    if (fault_i.over_temp) begin
      half = `MSSC_OT_MS * `MSSC_MS_CYC;
    end
    if (fault_i.over_volt) begin
      half = `MSSC_OV_MS * `MSSC_MS_CYC;
    end
    blink_next = blink_reg + 32'd1;
    led_next = led_reg;
    if (!any_fault) begin
      blink_next = 32'd0;
      led_next = 1'b0;
    end else if (fault_i.over_volt && fault_i.over_temp) begin
      blink_next = 32'd0;
      led_next = 1'b1;
    end else if (blink_reg >= half - 32'd1) begin
      blink_next = 32'd0;
      led_next = !led_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      blink_reg <= 32'd0;
      led_reg <= 1'b0;
    end else begin
      blink_reg <= blink_next;
      led_reg <= led_next;
    end
  end
  assign fault_led_o = led_reg;

  // ----------------------------------------------------------------
  // Fault log.
  // ----------------------------------------------------------------
  logic [31:0] logt_reg, logt_next;
  logic [2:0] byte_reg, byte_next;
  logic [7:0] ldat_reg, ldat_next;

  always_comb begin
    logt_next = logt_reg + 32'd1;
    byte_next = byte_reg;
    ldat_next = ldat_reg;
    if (!any_fault) begin
      logt_next = 32'd0;
    end
    if (byte_reg != 3'd0) begin
      if (log_ready_i) begin
        byte_next = byte_reg - 3'd1;
        if (byte_reg == 3'd2) begin
          ldat_next = mssc_code(fault_i);
        end else begin
          ldat_next = `MSSC_LOG_FILL;
        end
      end
    end else if (any_fault && logt_reg >= `MSSC_LOG_MS * `MSSC_MS_CYC - 32'd1) begin
      logt_next = 32'd0;
      if (cfg_reg04_i[`MSSC_CFG_LOG_BIT]) begin
        byte_next = 3'd4;
        ldat_next = `MSSC_LOG_FILL;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      logt_reg <= 32'd0;
      byte_reg <= 3'd0;
      ldat_reg <= 8'h00;
    end else begin
      logt_reg <= logt_next;
      byte_reg <= byte_next;
      ldat_reg <= ldat_next;
    end
  end

  assign log_valid_o = byte_reg != 3'd0;
  assign log_data_o = ldat_reg;
endmodule : mssc_top

/* hdl/mssc_regs.svh */
// Timing counts, field positions and codes of the status and mode-control block.
`ifndef MSSC_REGS_SVH
`define MSSC_REGS_SVH
`define MSSC_CLK_MHZ 250
`define MSSC_SWITCH_US 1000
`define MSSC_SWITCH_CYC (`MSSC_SWITCH_US * `MSSC_CLK_MHZ)
`define MSSC_SETTLE_US 2000
`define MSSC_SETTLE_CYC (`MSSC_SETTLE_US * `MSSC_CLK_MHZ)
`define MSSC_UV_MS 500
`define MSSC_OV_MS 1000
`define MSSC_OT_MS 2000
`define MSSC_LOG_MS 500
`define MSSC_MS_CYC (1000 * `MSSC_CLK_MHZ)
`define MSSC_SELFTEST_CYC 32'd64
`define MSSC_RELOAD_CYC 32'd32
`define MSSC_CFG_LOG_BIT 2
`define MSSC_CFG_DEFAULT 8'h00
`define MSSC_ADDR_ALL 16'hffff
`define MSSC_LOG_FILL 8'hff
`define MSSC_CODE_UV 8'h01
`define MSSC_CODE_OV 8'h02
`define MSSC_CODE_OT 8'h03
`define MSSC_CODE_OVOT 8'h04
`endif

/* hdl/mssc_pkg.sv */
// Types shared by the status and mode-control block.
package mssc_pkg;
  typedef enum logic [1:0] {
    MSSC_MODE_XFER,
    MSSC_MODE_WOR,
    MSSC_MODE_CFG,
    MSSC_MODE_SLEEP
  } mssc_mode_t;
  typedef struct packed {
    logic under_volt;
    logic over_volt;
    logic over_temp;
  } mssc_fault_t;
  typedef struct packed {
    logic tx_buf_busy;
    logic rx_out_busy;
    logic user_data_busy;
  } mssc_busy_t;
  typedef struct packed {
    logic [15:0] own_addr;
    logic [15:0] dest_addr;
    logic [7:0] own_chan;
    logic [7:0] pkt_chan;
  } mssc_addr_t;
endpackage : mssc_pkg

/* bench/mssc_properties.sv */
// Port checker of the status and mode-control block.
`timescale 1ns/10ps
`include "mssc_regs.svh"
module mssc_properties (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic srst_i,
  // Watched inputs.
  input wire mssc_pkg::mssc_busy_t busy_src_i,
  input wire mssc_pkg::mssc_fault_t fault_i,
  input wire logic [7:0] cfg_reg04_i,
  input wire mssc_pkg::mssc_addr_t addr_i,
  // Watched outputs.
  input wire logic log_valid_o,
  input wire logic [7:0] log_data_o,
  input wire logic busy_n_o,
  input wire logic fault_led_o,
  input wire mssc_pkg::mssc_mode_t mode_o,
  input wire logic radio_tx_en_o,
  input wire logic rx_accept_o
);
  import mssc_pkg::*;
  // ----------------------------------------
  // Idle time counter and properties.
  // ----------------------------------------
  logic [19:0] hi_cnt_reg;
  logic [19:0] hi_cnt_next;
  always_comb begin
    hi_cnt_next = (srst_i || !busy_n_o) ? 20'h0 : hi_cnt_reg + {19'h0, ~&hi_cnt_reg};
  end
  always_ff @(posedge mclk_i) begin
    hi_cnt_reg <= hi_cnt_next;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  busy_src_low_a: assert property ((|busy_src_i) |=> !busy_n_o)
    else $error("busy not low");
  busy_idle_a: assert property (busy_n_o |-> $past(busy_src_i) == '0)
    else $error("busy high with source");
  selftest_low_a: assert property ($fell(srst_i) |-> ##60 !busy_n_o)
    else $error("busy high in self-test");
  busy_hold_mode_a: assert property ((|busy_src_i) [*2] |=> $stable(mode_o))
    else $error("mode moved while busy");
  settle_wait_a: assert property ($changed(mode_o) && $past(busy_n_o) |->
    $past(hi_cnt_reg) >= `MSSC_SETTLE_CYC - 2) else $error("mode switched early");
  fault_tx_off_a: assert property ((|fault_i) |-> !radio_tx_en_o)
    else $error("transmit on in fault");
  fault_steady_a: assert property ((fault_i.over_volt && fault_i.over_temp) [*2] |-> fault_led_o)
    else $error("fault pin not steady");
  bcast_accept_a: assert property (addr_i.own_chan == addr_i.pkt_chan &&
    (addr_i.own_addr == `MSSC_ADDR_ALL || addr_i.dest_addr == `MSSC_ADDR_ALL) |=> rx_accept_o)
    else $error("all-ones address refused");
  log_head_a: assert property ($rose(log_valid_o) |-> log_data_o == `MSSC_LOG_FILL &&
    $past(cfg_reg04_i[`MSSC_CFG_LOG_BIT])) else $error("bad log start");
  cover property ($rose(busy_n_o));
  cover property ((|fault_i) ##1 fault_led_o);
  cover property (rx_accept_o);
endmodule : mssc_properties
bind mssc_top mssc_properties u_chk (.*);

/* bench/mssc_host_model.sv */
// Host controller model driving the mode pins and watching busy.
`timescale 1ns/10ps
module mssc_host_model (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic srst_i,
  // Bench request and block status.
  input wire logic [1:0] mode_req_i,
  input wire logic busy_n_i,
  // Pins toward the block, and the ready flag back to the bench.
  output logic mode_select_low_o,
  output logic mode_select_high_o,
  output logic log_ready_o,
  output logic ready_o
);
  // ----------------------------------------
  // Pin drive and start-up detection.
  // ----------------------------------------
  assign {mode_select_high_o, mode_select_low_o} = mode_req_i;
  always_ff @(posedge mclk_i) begin
    log_ready_o <= ~log_ready_o | srst_i;
    if (srst_i) begin
      ready_o <= 1'b0;
    end else if (busy_n_i) begin
      ready_o <= 1'b1;
    end
  end
endmodule : mssc_host_model

/* bench/tb.sv */
// Self-checking bench of the status and mode-control block.
`timescale 1ns/10ps
module tb;
  import mssc_pkg::*;
  logic mclk_i, srst_i, mlo, mhi, lrdy, lval, busy_n, led, ser, rrx, rtx, cfga, acc, hrdy;
  logic [7:0] ldat, cfg;
  logic [1:0] mreq;
  mssc_busy_t bsrc;
  mssc_fault_t flt;
  mssc_addr_t addr;
  mssc_mode_t mode;
  int n_fail, comparisons;
  mssc_top u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .mode_select_low_i(mlo),
    .mode_select_high_i(mhi), .busy_src_i(bsrc), .fault_i(flt), .cfg_reg04_i(cfg),
    .addr_i(addr), .log_ready_i(lrdy), .log_valid_o(lval), .log_data_o(ldat),
    .busy_n_o(busy_n), .fault_led_o(led), .mode_o(mode), .serial_en_o(ser),
    .radio_rx_en_o(rrx), .radio_tx_en_o(rtx), .cfg_access_o(cfga), .rx_accept_o(acc));
  mssc_host_model u_host (.mclk_i(mclk_i), .srst_i(srst_i), .mode_req_i(mreq),
    .busy_n_i(busy_n), .mode_select_low_o(mlo), .mode_select_high_o(mhi),
    .log_ready_o(lrdy), .ready_o(hrdy));
  // ----------------------------------------
  // Clock, checks and scenarios.
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  task automatic t_reset(input logic [1:0] m);
    int i;
    @(posedge mclk_i);
    mreq <= m;
    srst_i <= 1'b1;
    cyc(4);
    srst_i <= 1'b0;
    cyc(50);
    @(negedge mclk_i);
    chk("busy", busy_n, 1'b0);
    for (i = 0; i < 100 && hrdy !== 1'b1; i++) @(negedge mclk_i);
    if (hrdy !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    chk("mode", mode, m);
    chk("cfg", cfga, m == 2'h2);
    if (m == 2'h0) chk("xfer", {ser, rrx, rtx}, 3'h7);
  endtask : t_reset
  task automatic t_busy;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i);
      bsrc <= 3'h1 << i;
      mreq <= 2'h2;
      cyc(3);
      @(negedge mclk_i);
      chk("busy", busy_n, 1'b0);
      chk("held", mode, MSSC_MODE_XFER);
      @(posedge mclk_i);
      mreq <= 2'h0;
      cyc(2);
      bsrc <= '0;
      cyc(2);
      @(negedge mclk_i);
      chk("idle", busy_n, 1'b1);
    end
  endtask : t_busy
  task automatic t_fault;
    @(posedge mclk_i);
    flt <= 3'h3;
    cfg <= 8'h04;
    cyc(4);
    @(negedge mclk_i);
    chk("led", led, 1'b1);
    chk("tx", rtx, 1'b0);
    chk("logv", lval, 1'b0);
    chk("logd", ldat, 8'h00);
    @(posedge mclk_i);
    flt <= '0;
    cyc(3);
    @(negedge mclk_i);
    chk("tx", rtx, 1'b1);
    chk("led", led, 1'b0);
  endtask : t_fault
  task automatic t_addr;
    logic [47:0] tbl [4];
    tbl = '{48'hffff_1234_0404, 48'h5678_ffff_0404, 48'hffff_ffff_0405, 48'h0001_0002_0404};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      addr <= tbl[i];
      @(posedge mclk_i);
      @(negedge mclk_i);
      chk("accept", acc, i < 2);
    end
  endtask : t_addr
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    n_fail = 0;
    comparisons = 0;
    {srst_i, mreq, bsrc, flt, cfg, addr} = {1'b1, 64'h0};
    cyc(4);
    for (int m = 3; m >= 0; m--) t_reset(m[1:0]);
    t_busy();
    t_fault();
    t_addr();
    tally_and_finish();
  end
endmodule : tb
